// ==== gated_shifter.sv ====
// Contract
// - eight chained stages, each shown on output
// - either serial input low loads zero
// - entering bit is AND of inputs
// - shift only on shift clock rising edge
// - active-low clear zeroes all stages asynchronously
// - no edge, no clear: stages hold
// - each shift clock rising edge shifts stages one position
module gated_shifter (
  // clock and the two clears
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_zero_n,
  // serial side, sampled on core_clk
  input wire logic shift_clk,
  input wire logic serial_a,
  input wire logic serial_b,
  // one output per stage, stage 0 first
  output logic stage0_out,
  output logic stage1_out,
  output logic stage2_out,
  output logic stage3_out,
  output logic stage4_out,
  output logic stage5_out,
  output logic stage6_out,
  output logic stage7_out,
  // snapshot buffer toward the reader
  output logic snap_ready,
  output logic word_valid,
  output logic [7:0] word_data,
  input wire logic word_ready
);

  shifter_pkg::state_t st;
  shifter_pkg::state_t next_st;
  logic rise;
  logic entry_bit;
  logic [shifter_pkg::STAGE_COUNT-1:0] shifted;
  logic [shifter_pkg::STAGE_COUNT-1:0] next_stages;
  logic next_clk_prev;
  logic pop;
  logic push;
  shifter_pkg::slot_t next_head;
  shifter_pkg::slot_t next_tail;
  logic next_snap_ready;

  // a rise is a low sample of the shift clock followed by a high one
  always_comb begin
    rise = 1'h0;
    unique case ({shift_clk, st.clk_prev})
      2'b00: rise = 1'h0;
      2'b01: rise = 1'h0;
      2'b10: rise = 1'h1;
      2'b11: rise = 1'h0;
    endcase
  end

  // edge history, preset high by either clear
  always_comb begin
    next_clk_prev = shift_clk;
  end

  // gated entry bit: a low on either input wins
  always_comb begin
    entry_bit = 1'h0;
    unique case ({serial_a, serial_b})
      2'b00: entry_bit = 1'h0;
      2'b01: entry_bit = 1'h0;
      2'b10: entry_bit = 1'h0;
      2'b11: entry_bit = 1'h1;
    endcase
  end

  // stage 0 takes the entry bit, every later stage its predecessor
  assign shifted[0] = entry_bit;
  for (genvar i = 1; i < shifter_pkg::STAGE_COUNT; i++) begin : g_chain
    assign shifted[i] = st.stages[i-1];
  end

  // hold unless a rise was seen
  always_comb begin
    if (rise) begin
      next_stages = shifted;
    end else begin
      next_stages = st.stages;
    end
  end

  // the head is offered until the reader takes it
  always_comb begin
    pop = 1'h0;
    if (st.head.valid && word_ready) begin
      pop = 1'h1;
    end
  end

  // a shift with a full tail still shifts, only its snapshot is lost
  always_comb begin
    push = 1'h0;
    if (rise && !st.tail.valid) begin
      push = 1'h1;
    end
  end

  // head slot: refilled from the tail on a pop, from the stages on a push that finds it empty or being popped
  always_comb begin
    unique case ({pop, push, st.head.valid})
      3'b000: begin
        next_head.valid = st.head.valid;
        next_head.data = st.head.data;
      end
      3'b001: begin
        next_head.valid = st.head.valid;
        next_head.data = st.head.data;
      end
      3'b010: begin
        next_head.valid = 1'h1;
        next_head.data = shifted;
      end
      3'b011: begin
        next_head.valid = st.head.valid;
        next_head.data = st.head.data;
      end
      3'b101: begin
        next_head.valid = st.tail.valid;
        next_head.data = st.tail.data;
      end
      // push implies an empty tail, so the new word becomes head
      3'b111: begin
        next_head.valid = 1'h1;
        next_head.data = shifted;
      end
      // a pop with an empty head cannot occur
      default: begin
        next_head.valid = st.head.valid;
        next_head.data = st.head.data;
      end
    endcase
  end

  // tail slot: filled only when a push finds the head occupied
  always_comb begin
    unique case ({pop, push, st.head.valid})
      3'b000: begin
        next_tail.valid = st.tail.valid;
        next_tail.data = st.tail.data;
      end
      3'b001: begin
        next_tail.valid = st.tail.valid;
        next_tail.data = st.tail.data;
      end
      3'b010: begin
        next_tail.valid = st.tail.valid;
        next_tail.data = st.tail.data;
      end
      // push is only allowed with an empty tail
      3'b011: begin
        next_tail.valid = 1'h1;
        next_tail.data = shifted;
      end
      3'b101: begin
        next_tail.valid = 1'h0;
        next_tail.data = st.tail.data;
      end
      // pop and push together leave the tail empty
      3'b111: begin
        next_tail.valid = 1'h0;
        next_tail.data = st.tail.data;
      end
      // a pop with an empty head cannot occur
      default: begin
        next_tail.valid = st.tail.valid;
        next_tail.data = st.tail.data;
      end
    endcase
  end

  // free slot means the tail is empty after this edge
  always_comb begin
    next_snap_ready = 1'h1;
    if (next_tail.valid) begin
      next_snap_ready = 1'h0;
    end
  end

  // one copy of the state, registered below
  always_comb begin
    next_st.stages = next_stages;
    next_st.clk_prev = next_clk_prev;
    next_st.head.valid = next_head.valid;
    next_st.head.data = next_head.data;
    next_st.tail.valid = next_tail.valid;
    next_st.tail.data = next_tail.data;
    next_st.snap_ready = next_snap_ready;
  end

  // either clear flushes the buffer and presets the edge history high,
  // so a shift clock that is high at release cannot look like a rise
  always_ff @(posedge core_clk or posedge rst or negedge async_zero_n) begin
    if (rst || !async_zero_n) begin
      st <= shifter_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // parallel view of the chain
  assign stage0_out = st.stages[0];
  assign stage1_out = st.stages[1];
  assign stage2_out = st.stages[2];
  assign stage3_out = st.stages[3];
  assign stage4_out = st.stages[4];
  assign stage5_out = st.stages[5];
  assign stage6_out = st.stages[6];
  assign stage7_out = st.stages[7];
  assign snap_ready = st.snap_ready;
  assign word_valid = st.head.valid;
  assign word_data = st.head.data;

endmodule : gated_shifter

// ==== gated_shifter_tb_top.sv ====
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module gated_shifter_tb_top;
  timeunit 1ns; timeprecision 1ns;
  logic core_clk = 0, rst = 1, async_zero_n = 1, word_ready = 0, p, k, shift_clk, serial_a;
  logic serial_b, snap_ready, word_valid, stage0_out, stage1_out, stage2_out, stage3_out;
  logic stage4_out, stage5_out, stage6_out, stage7_out;
  logic [7:0] word_data, m, q[$];
  wire [7:0] outs = {stage7_out, stage6_out, stage5_out, stage4_out, stage3_out, stage2_out,
    stage1_out, stage0_out};
  int seed = 36, n_errors = 0, compares = 0;
  gated_shifter gated_shifter_inst (.*);
  shifter_drv shifter_drv_inst (.*);
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk or negedge async_zero_n) begin
    k = q.size() < 2;
    if (q.size() > 0 && word_ready) void'(q.pop_front());
    if (shift_clk && !p) m = {m[6:0], serial_a & serial_b};
    if (shift_clk && !p && k) q.push_back(m);
    p = shift_clk;
    if (rst || !async_zero_n) begin m = 0; p = 1; q = {}; end
  end
  always @(negedge core_clk) if (!rst) begin
    `CHK(outs, m)
    `CHK({word_valid, snap_ready}, {q.size() > 0, q.size() < 2})
    if (q.size() > 0) `CHK(word_data, q[0])
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    repeat (4000) @(posedge core_clk) begin
      word_ready <= 1'($random(seed));
      async_zero_n <= $random(seed) % 97 != 0;
    end
    give_verdict;
  end
  initial begin #30000; n_errors++; give_verdict; end
  task give_verdict;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
endmodule : gated_shifter_tb_top
bind gated_shifter shifter_checker shifter_checker_inst (.*);

// ==== shifter_checker.sv ====
module shifter_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_zero_n,
  input wire logic shift_clk,
  input wire logic serial_a,
  input wire logic serial_b,
  input wire logic stage0_out,
  input wire logic stage1_out,
  input wire logic stage2_out,
  input wire logic stage3_out,
  input wire logic stage4_out,
  input wire logic stage5_out,
  input wire logic stage6_out,
  input wire logic stage7_out,
  input wire logic snap_ready,
  input wire logic word_valid,
  input wire logic [7:0] word_data,
  input wire logic word_ready
);
  wire [7:0] stages = {stage7_out, stage6_out, stage5_out, stage4_out, stage3_out, stage2_out,
    stage1_out, stage0_out};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !async_zero_n);
  // a rise that follows an edge with both clears off
  sequence s_rise;
    $rose(shift_clk) && $past(async_zero_n) && !$past(rst);
  endsequence
  sequence s_rise_empty;
    $rose(shift_clk) && $past(async_zero_n) && !$past(rst) && !word_valid;
  endsequence
  sequence s_no_rise;
    !$rose(shift_clk);
  endsequence
  a_entry_bit: assert property (s_rise |=> stage0_out == $past(serial_a & serial_b))
    else $error("bad entry bit");
  a_shift_move: assert property (s_rise |=> stages[7:1] == $past(stages[6:0]))
    else $error("stages did not shift");
  a_hold_stages: assert property (s_no_rise |=> $stable(stages))
    else $error("stages changed without a rise");
  a_clear_zero: assert property (disable iff (rst) !async_zero_n |-> stages == 8'h00)
    else $error("clear did not zero the stages");
  a_resume_zero: assert property ($rose(async_zero_n) |-> stages == 8'h00)
    else $error("stages not zero after clear");
  a_word_taken: assert property (s_rise_empty |=> word_valid && word_data == stages)
    else $error("snapshot not offered");
  a_ready_free: assert property (!word_valid |-> snap_ready)
    else $error("empty buffer shows no free slot");
endmodule : shifter_checker

// ==== shifter_drv.sv ====
module shifter_drv (
  input wire logic core_clk,
  output logic shift_clk,
  output logic serial_a,
  output logic serial_b
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 36;
  initial begin
    shift_clk = 1'h1;
    serial_a = 1'h0;
    serial_b = 1'h0;
  end
  // shift clock pauses at random; serial data moves only while it is high
  always @(posedge core_clk) begin
    if ($random(seed) % 4 != 0) shift_clk <= ~shift_clk;
    if (shift_clk) {serial_a, serial_b} <= 2'($random(seed));
  end
endmodule : shifter_drv

// ==== shifter_pkg.sv ====
package shifter_pkg;

  localparam int STAGE_COUNT = 8;
  localparam logic [7:0] STAGES_RESET = 8'h00;
  localparam logic CLK_PREV_RESET = 1'h1;
  localparam logic SNAP_READY_RESET = 1'h1;

  typedef struct packed {
    logic valid;
    logic [STAGE_COUNT-1:0] data;
  } slot_t;

  typedef struct packed {
    logic [STAGE_COUNT-1:0] stages;
    logic clk_prev;
    slot_t head;
    slot_t tail;
    logic snap_ready;
  } state_t;

  localparam state_t STATE_RESET = '{
    stages: STAGES_RESET,
    clk_prev: CLK_PREV_RESET,
    head: '{valid: 1'h0, data: STAGES_RESET},
    tail: '{valid: 1'h0, data: STAGES_RESET},
    snap_ready: SNAP_READY_RESET
  };

endpackage : shifter_pkg
